// ### csa_alu.sv
// Purpose: Execution datapath for extended shift, subtract, swap and sign-extend
// Assumes: Avalon-MM slave with waitrequest; operands written before GO
// Notes: Result and flags land one cycle after GO; status word readable
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
// Behaviour
// - Multi-shift: right shift by one to four, zeros enter top, unsigned divide.
// - Word multi-shift forces result bits 19:16 to zero.
// - Multi-shift N is bit 19 or 15 by size; Z means zero result.
// - Multi-shift carry gets original bit n-1; overflow cleared.
// - Multi-shift decoded without an extension word; one is illegal.
// - Single-bit unsigned shift: register only, zero into top, low bit to carry.
// - Single-bit shift byte clears bits 19:8, word clears 19:16.
// - Single-bit shift N from bit 7, 15 or 19; C old low bit; V cleared.
// - Borrow-subtract: destination plus all-ones of width plus carry.
// - Borrow-subtract carry set with no borrow, cleared on borrow.
// - Subtracts treat carry as inverted borrow.
// - Extended subtract adds inverted source plus one; source unchanged.
// - Extended subtract N on negative, Z on equality, C on carry out.
// - Subtract V on sign overflow of opposite-signed operands.
// - Subtract-with-carry adds inverted source plus carry flag.
// - Register swap exchanges bytes; address-word keeps 19:16, word clears.
// - Memory address-word swap clears 31:20, keeps 19:16; word swaps word only.
// - Byte swap leaves N, Z, C and V unchanged.
// - No operation touches oscillator-off, core-off or interrupt enable bits.
// - Sign extend copies bit 7 upward; register mode fills bits 19:8.
module csa_alu (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic busy, // Operation in flight
  output logic illegal_r // Last command rejected
);

  // ==========================================================
  // Registers
  csa_pkg::csa_cmd_t cmd_r;
  logic [31:0] dst_r;
  logic [31:0] src_r;
  logic [8:0] sr_r;
  logic go_r;
  logic rd_pend_r;
  logic [31:0] wdata;
  logic [31:0] ctrl_word;

  // Merge byte lanes over the current value
  // Shared by every writable register so partial writes behave alike
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : lane_merge

  // Control writes merge over the readable image; untouched lanes keep their fields
  assign ctrl_word = {18'h0_0000, cmd_r.has_ext, cmd_r.mem_mode, 1'b0, cmd_r.count, 2'b00, cmd_r.size, cmd_r.op};
  assign wdata = lane_merge(ctrl_word, avs_writedata, avs_byteenable);

  // ==========================================================
  // Datapath
  logic [19:0] res_nxt;
  logic [31:0] mem_nxt;
  csa_pkg::csa_flags_t fl_nxt;
  logic upd_flags;
  logic illegal_nxt;
  logic [19:0] d;
  logic [19:0] s;
  logic [19:0] mask;
  logic [19:0] msb;
  logic [20:0] sum;
  logic cin;
  logic dneg;
  logic sneg;
  logic rneg;

  // Operand width masks; bits above the width reach a result only in memory-word swap and sign extend
  always_comb begin
    d = dst_r[19:0];
    s = src_r[19:0];
    case (cmd_r.size)
      csa_pkg::SZ_BYTE: begin
        mask = 20'h0_00FF;
        msb = 20'h0_0080;
      end
      csa_pkg::SZ_WORD: begin
        mask = 20'h0_FFFF;
        msb = 20'h0_8000;
      end
      default: begin
        mask = 20'hF_FFFF;
        msb = 20'h8_0000;
      end
    endcase
  end

  // Adder shared by all subtract forms
  always_comb begin
    cin = 1'b0;
    sum = 21'h00_0000;
    case (cmd_r.op)
      csa_pkg::OP_BORROW_SUB: begin
        cin = sr_r[csa_pkg::SR_C];
        sum = {1'b0, d & mask} + {1'b0, mask} + {20'h0_0000, cin};
      end
      csa_pkg::OP_EXT_SUB: begin
        cin = 1'b1;
        sum = {1'b0, d & mask} + {1'b0, ~s & mask} + {20'h0_0000, cin};
      end
      csa_pkg::OP_SUB_CARRY: begin
        cin = sr_r[csa_pkg::SR_C];
        sum = {1'b0, d & mask} + {1'b0, ~s & mask} + {20'h0_0000, cin};
      end
      default: begin
        sum = 21'h00_0000;
      end
    endcase
  end

  always_comb begin
    res_nxt = d;
    mem_nxt = dst_r;
    fl_nxt = '{v: sr_r[csa_pkg::SR_V], n: sr_r[csa_pkg::SR_N], z: sr_r[csa_pkg::SR_Z], c: sr_r[csa_pkg::SR_C]};
    upd_flags = 1'b1;
    illegal_nxt = 1'b0;
    dneg = |(d & msb);
    // Borrow-subtract has an implied zero source, which is never negative
    sneg = (cmd_r.op != csa_pkg::OP_BORROW_SUB) && |(s & msb);
    rneg = 1'b0;
    case (cmd_r.op)
      csa_pkg::OP_MULTI_SHIFT: begin
        // Byte size and counts outside one to four are refused too
        // no extension word
        if (cmd_r.has_ext || cmd_r.mem_mode || cmd_r.size == csa_pkg::SZ_BYTE ||
            cmd_r.count == 3'd0 || cmd_r.count > 3'd4) begin
          illegal_nxt = 1'b1;
          upd_flags = 1'b0;
        end else begin
          res_nxt = (d & mask) >> cmd_r.count;
          res_nxt = res_nxt & mask;
          fl_nxt.c = d[cmd_r.count - 3'd1];
          fl_nxt.v = 1'b0;
          fl_nxt.n = |(res_nxt & msb);
          fl_nxt.z = (res_nxt == 20'h0_0000);
        end
      end
      csa_pkg::OP_SINGLE_SHIFT: begin
        // Memory destinations have no encoding for this shift
        // register destination only
        if (cmd_r.mem_mode) begin
          illegal_nxt = 1'b1;
          upd_flags = 1'b0;
        end else begin
          res_nxt = (d & mask) >> 1;
          fl_nxt.n = |(res_nxt & msb);
          fl_nxt.z = (res_nxt == 20'h0_0000);
          fl_nxt.c = d[0];
          fl_nxt.v = 1'b0;
        end
      end
      csa_pkg::OP_BORROW_SUB, csa_pkg::OP_EXT_SUB, csa_pkg::OP_SUB_CARRY: begin
        res_nxt = sum[19:0] & mask;
        mem_nxt = {12'h000, res_nxt};
        rneg = |(res_nxt & msb);
        fl_nxt.n = rneg;
        fl_nxt.z = (res_nxt == 20'h0_0000);
        // Carry out sits at bit 8, 16 or 20 by size
        // carry is not-borrow
        case (cmd_r.size)
          csa_pkg::SZ_BYTE: fl_nxt.c = sum[8];
          csa_pkg::SZ_WORD: fl_nxt.c = sum[16];
          default: fl_nxt.c = sum[20];
        endcase
        fl_nxt.v = (~dneg & sneg & rneg) | (dneg & ~sneg & ~rneg);
      end
      csa_pkg::OP_BYTE_SWAP: begin
        // Swap has no byte form, so that code is refused
        // flags held
        upd_flags = 1'b0;
        if (cmd_r.size == csa_pkg::SZ_BYTE) begin
          illegal_nxt = 1'b1;
        end else if (cmd_r.mem_mode) begin
          if (cmd_r.size == csa_pkg::SZ_AWORD) begin
            mem_nxt = {12'h000, dst_r[19:16], dst_r[7:0], dst_r[15:8]};
          end else begin
            mem_nxt = {dst_r[31:16], dst_r[7:0], dst_r[15:8]};
          end
          res_nxt = mem_nxt[19:0];
        end else begin
          res_nxt = {(cmd_r.size == csa_pkg::SZ_AWORD) ? d[19:16] : 4'h0, d[7:0], d[15:8]};
        end
      end
      csa_pkg::OP_SIGN_EXT: begin
        if (cmd_r.size == csa_pkg::SZ_BYTE) begin
          illegal_nxt = 1'b1;
          upd_flags = 1'b0;
        end else begin
          // Register mode fills 19:8 at either size
          if (!cmd_r.mem_mode) begin
            res_nxt = {{12{d[7]}}, d[7:0]};
            mem_nxt = {12'h000, res_nxt};
          end else if (cmd_r.size == csa_pkg::SZ_AWORD) begin
            // Memory address-word clears 31:20
            res_nxt = {{12{d[7]}}, d[7:0]};
            mem_nxt = {12'h000, res_nxt};
          end else begin
            // Memory word extends only into 15:8
            res_nxt = {d[19:16], {8{d[7]}}, d[7:0]};
            mem_nxt = {dst_r[31:16], {8{d[7]}}, d[7:0]};
          end
          fl_nxt.n = |(res_nxt & msb);
          fl_nxt.z = ((res_nxt & mask) == 20'h0_0000);
          fl_nxt.c = ~fl_nxt.z;
          fl_nxt.v = 1'b0;
        end
      end
      default: begin
        illegal_nxt = 1'b1;
        upd_flags = 1'b0;
      end
    endcase
    // Register mode clears bits 31:20 of the written-back word for every legal command
    if (!cmd_r.mem_mode && !illegal_nxt) begin
      mem_nxt = {12'h000, res_nxt};
    end
  end

  // ==========================================================
  // Write decode
  logic wr_take;
  logic wr_ctrl;
  logic wr_dst;
  logic wr_src;
  logic wr_stat;

  // Writes are taken only outside the execute cycle, the same term that stalls them
  assign wr_take = avs_write & ~busy;
  assign wr_ctrl = wr_take & (avs_address == csa_pkg::OFS_CTRL);
  assign wr_dst = wr_take & (avs_address == csa_pkg::OFS_DST);
  assign wr_src = wr_take & (avs_address == csa_pkg::OFS_SRC);
  assign wr_stat = wr_take & (avs_address == csa_pkg::OFS_RES);

  // ==========================================================
  // Command register
  // Reset value is a legal word shift by one, so a stray start is harmless
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r <= '{op: csa_pkg::OP_MULTI_SHIFT, size: csa_pkg::SZ_WORD, count: 3'd1, mem_mode: 1'b0, has_ext: 1'b0};
    end else if (wr_ctrl) begin
      cmd_r.op <= csa_pkg::csa_op_t'(wdata[csa_pkg::CTRL_OP_LSB +: 4]);
      cmd_r.size <= csa_pkg::csa_size_t'(wdata[csa_pkg::CTRL_SZ_LSB +: 2]);
      cmd_r.count <= wdata[csa_pkg::CTRL_CNT_LSB +: 3];
      cmd_r.mem_mode <= wdata[csa_pkg::CTRL_MEM_BIT];
      cmd_r.has_ext <= wdata[csa_pkg::CTRL_EXT_BIT];
    end
  end

  // Start pulse; one cycle wide, and the start bit is never stored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      go_r <= 1'b0;
    end else begin
      go_r <= wr_ctrl & avs_byteenable[3] & avs_writedata[csa_pkg::CTRL_GO_BIT];
    end
  end

  // ==========================================================
  // Operand registers
  // Destination takes the result in the execute cycle; a write there is stalled anyway
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dst_r <= 32'h0000_0000;
    end else if (go_r) begin
      dst_r <= mem_nxt;
    end else if (wr_dst) begin
      dst_r <= lane_merge(dst_r, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      src_r <= 32'h0000_0000;
    end else if (wr_src) begin
      src_r <= lane_merge(src_r, avs_writedata, avs_byteenable);
    end
  end

  // ==========================================================
  // Status
  // Reject flag follows every executed command, legal or not
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      illegal_r <= 1'b0;
    end else if (go_r) begin
      illegal_r <= illegal_nxt;
    end
  end

  // Status word; software writes stall in the execute cycle, so execution owns it then
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sr_r <= csa_pkg::SR_RESET;
    end else if (go_r) begin
      if (upd_flags) begin
        sr_r[csa_pkg::SR_C] <= fl_nxt.c;
        sr_r[csa_pkg::SR_Z] <= fl_nxt.z;
        sr_r[csa_pkg::SR_N] <= fl_nxt.n;
        sr_r[csa_pkg::SR_V] <= fl_nxt.v;
      end
    end else if (wr_stat) begin
      sr_r <= 9'(lane_merge({23'h00_0000, sr_r}, avs_writedata, avs_byteenable));
    end
  end

  // ==========================================================
  // Read path
  // One wait cycle buys registered read data with no combinational mux on the bus
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= avs_read & ~rd_pend_r;
    end
  end

  // Read data holds between reads
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_pend_r) begin
      case (avs_address)
        csa_pkg::OFS_CTRL: avs_readdata <= ctrl_word;
        csa_pkg::OFS_DST: avs_readdata <= dst_r;
        csa_pkg::OFS_SRC: avs_readdata <= src_r;
        csa_pkg::OFS_RES: avs_readdata <= {23'h00_0000, sr_r};
        default: avs_readdata <= csa_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // ==========================================================
  // Handshake
  // Busy is the execute cycle itself; execution takes exactly one cycle
  assign busy = go_r;
  // Writes stall while executing; reads wait one cycle for registered data
  assign avs_waitrequest = (avs_read & ~rd_pend_r) | (avs_write & busy);

endmodule : csa_alu

// ### csa_alu_asserts.sv
// Purpose: Bus and sequencing assertions for csa_alu
// Assumes: Sees only the top-level ports
// Notes: Bound to every csa_alu instance
`timescale 1ns/10ps
module csa_alu_chk (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic [3:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic busy, // In flight
  input wire logic illegal_r // Rejected
);
  // ==========================================================
  // Shared clocking
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Start write accepted; needs the top lane for the start bit
  wire go_w = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_writedata[31] && avs_byteenable[3];
  // ==========================================================
  // Assertions
  chk_go_busy_pulse: assert property (go_w |=> busy ##1 !busy)
    else $error("busy not one cycle after start");
  chk_busy_cause: assert property (busy |-> $past(go_w))
    else $error("busy without start");
  chk_read_first_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait state");
  chk_read_one_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read stalled too long");
  chk_write_stall: assert property (avs_write |-> avs_waitrequest == busy)
    else $error("write stall wrong");
  chk_idle_ready: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("stall while idle");
  chk_flag_timing: assert property ($changed(illegal_r) |-> $past(busy))
    else $error("reject flag moved outside execute");
  chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  // Main scenarios reached
  cover property (go_w);
  cover property (avs_write && busy);
  cover property ($rose(illegal_r));
endmodule : csa_alu_chk

bind csa_alu csa_alu_chk i_csa_alu_chk (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .illegal_r(illegal_r));

// ### csa_pkg.sv
// Purpose: Shared constants and types for the 20-bit shift/subtract/swap ALU
// Assumes: Single clock, registers reached over Avalon-MM with waitrequest
// Notes: Register offsets are byte addresses of aligned 32-bit words
package csa_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DST = 4'h4;
  localparam logic [3:0] OFS_SRC = 4'h8;
  localparam logic [3:0] OFS_RES = 4'hC;
  // Control field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SZ_LSB = 4;
  localparam int CTRL_CNT_LSB = 8;
  localparam int CTRL_MEM_BIT = 12;
  localparam int CTRL_EXT_BIT = 13;
  localparam int CTRL_GO_BIT = 31;
  // Status register field positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_GIE = 3;
  localparam int SR_CORE_OFF_BIT = 4;
  localparam int SR_OSCILLATOR_OFF_BIT = 5;
  localparam int SR_V = 8;
  localparam logic [8:0] SR_RESET = 9'h000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // Execution latency in cycles
  localparam int EXEC_CYCLES = 1;

  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    OP_MULTI_SHIFT = 4'b0000,
    OP_SINGLE_SHIFT = 4'b0001,
    OP_BORROW_SUB = 4'b0010,
    OP_EXT_SUB = 4'b0011,
    OP_SUB_CARRY = 4'b0100,
    OP_BYTE_SWAP = 4'b0101,
    OP_SIGN_EXT = 4'b0110
  } csa_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_AWORD = 2'b10
  } csa_size_t;

  // Command carried to the datapath
  typedef struct packed {
    csa_op_t op;
    csa_size_t size;
    logic [2:0] count;
    logic mem_mode;
    logic has_ext;
  } csa_cmd_t;

  // Flags produced by the datapath
  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } csa_flags_t;
endpackage : csa_pkg

// ### tb_csa_alu.sv
// Purpose: Self-checking bench for csa_alu
// Assumes: Reads take one wait state, writes stall only while busy
// Notes: Expected values worked out by hand for each case
`timescale 1ns/10ps
module tb_csa_alu;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  logic illegal_r;
  logic held = 1'b0;
  logic [31:0] q;
  int waits;
  int errors = 0;
  int num_checks = 0;

  csa_alu i_csa_alu (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .illegal_r(illegal_r));

  // ==========================================================
  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One bus transfer; keep leaves the strobe up so the next one follows at once
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic keep);
    if (!held) begin
      @(posedge sys_clk);
    end
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    waits = 0;
    do begin
      @(posedge sys_clk);
      waits++;
    end while (avs_waitrequest !== 1'b0 && waits < 16);
    q = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      report_and_stop();
    end
    held = keep;
    if (!keep) begin
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask : bus

  // Load operands and status, start, then read back destination, source and status
  task automatic do_op(input logic [31:0] c, d, input logic [19:0] s, input logic [8:0] sr,
                       input logic [19:0] ed, input logic [8:0] es, input logic il);
    bus(1'b1, 4'hC, {23'h00_0000, sr}, 1'b0);
    bus(1'b1, 4'h4, d, 1'b0);
    bus(1'b1, 4'h8, {12'h000, s}, 1'b0);
    bus(1'b1, 4'h0, c, 1'b0);
    @(posedge sys_clk);
    chk({31'h0000_0000, busy}, 32'h0000_0001);
    bus(1'b0, 4'h4, 32'h0000_0000, 1'b0);
    chk(q, {12'h000, ed});
    bus(1'b0, 4'h8, 32'h0000_0000, 1'b0);
    chk(q, {12'h000, s});
    bus(1'b0, 4'hC, 32'h0000_0000, 1'b0);
    chk(q, {23'h00_0000, es});
    chk({31'h0000_0000, illegal_r}, {31'h0000_0000, il});
  endtask : do_op

  task automatic sc_reset;
    bus(1'b0, 4'hC, 32'h0000_0000, 1'b0);
    chk(q, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000, 1'b0);
    chk(q, 32'h0000_0000);
  endtask : sc_reset

  task automatic sc_mshift;
    do_op(32'h8000_0420, 32'h0008_1238, 20'h0, 9'h138, 20'h0_8123, 9'h039, 1'b0);
    do_op(32'h8000_0110, 32'h000E_0002, 20'h0, 9'h000, 20'h0_0001, 9'h000, 1'b0);
    do_op(32'h8000_0220, 32'h0000_0003, 20'h0, 9'h000, 20'h0_0000, 9'h003, 1'b0);
    do_op(32'h8000_2120, 32'h0000_0010, 20'h0, 9'h001, 20'h0_0010, 9'h001, 1'b1);
  endtask : sc_mshift

  task automatic sc_sshift;
    do_op(32'h8000_0001, 32'h000F_FF81, 20'h0, 9'h000, 20'h0_0040, 9'h001, 1'b0);
    do_op(32'h8000_0021, 32'h0000_0001, 20'h0, 9'h104, 20'h0_0000, 9'h003, 1'b0);
    do_op(32'h8000_0011, 32'h000E_8002, 20'h0, 9'h000, 20'h0_4001, 9'h000, 1'b0);
    do_op(32'h8000_1021, 32'h0000_0002, 20'h0, 9'h000, 20'h0_0002, 9'h000, 1'b1);
  endtask : sc_sshift

  task automatic sc_sub;
    do_op(32'h8000_0012, 32'h0000_0000, 20'h0, 9'h000, 20'h0_FFFF, 9'h004, 1'b0);
    do_op(32'h8000_0012, 32'h0000_0005, 20'h0, 9'h001, 20'h0_0005, 9'h001, 1'b0);
    do_op(32'h8000_0022, 32'h0000_0001, 20'h0, 9'h000, 20'h0_0000, 9'h003, 1'b0);
    do_op(32'h8000_0023, 32'h0000_0001, 20'h2, 9'h000, 20'hF_FFFF, 9'h004, 1'b0);
    do_op(32'h8000_0013, 32'h0000_1234, 20'h1234, 9'h000, 20'h0_0000, 9'h003, 1'b0);
    do_op(32'h8000_0013, 32'h0000_7FFF, 20'hFFFF, 9'h000, 20'h0_8000, 9'h104, 1'b0);
    do_op(32'h8000_0004, 32'h0000_0010, 20'h1, 9'h000, 20'h0_000E, 9'h001, 1'b0);
    do_op(32'h8000_0004, 32'h0000_0080, 20'h1, 9'h001, 20'h0_007F, 9'h101, 1'b0);
  endtask : sc_sub

  task automatic sc_swap;
    do_op(32'h8000_0025, 32'h0002_3456, 20'h0, 9'h107, 20'h2_5634, 9'h107, 1'b0);
    do_op(32'h8000_0015, 32'h0002_3456, 20'h0, 9'h038, 20'h0_5634, 9'h038, 1'b0);
    do_op(32'h8000_1025, 32'hABC2_3456, 20'h0, 9'h000, 20'h2_5634, 9'h000, 1'b0);
    do_op(32'h8000_1015, 32'h0002_3456, 20'h0, 9'h000, 20'h2_5634, 9'h000, 1'b0);
    do_op(32'h8000_1026, 32'hABC0_0080, 20'h0, 9'h000, 20'hF_FF80, 9'h005, 1'b0);
    do_op(32'h8000_0016, 32'h0000_0080, 20'h0, 9'h000, 20'hF_FF80, 9'h005, 1'b0);
  endtask : sc_swap

  // Write right behind a start stalls once and lands after execution
  task automatic sc_stall;
    do_op(32'h8000_0013, 32'h0000_0005, 20'h2, 9'h000, 20'h0_0003, 9'h001, 1'b0);
    bus(1'b1, 4'h0, 32'h8000_0013, 1'b1);
    bus(1'b1, 4'h8, 32'h0000_0007, 1'b0);
    chk(32'(waits), 32'h0000_0002);
    bus(1'b0, 4'h4, 32'h0000_0000, 1'b0);
    chk(q, 32'h0000_0001);
  endtask : sc_stall

  // Reset, then every scenario in turn
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    sc_reset();
    sc_mshift();
    sc_sshift();
    sc_sub();
    sc_swap();
    sc_stall();
    report_and_stop();
  end
endmodule : tb_csa_alu
